/* File: rtl/smc_control_unit.sv */
// Overview of operation
// RULE_01 - Burst and auto-restart entry both wait out a 20 ms blanking.
// RULE_02 - Burst uses the fixed interval; auto restart may be extended.
// RULE_03 - After 20 ms auto restart still waits for the pin upper level.
// RULE_04 - Clamp switch on the blanking pin opens when 20 ms expires.
// RULE_05 - Auto restart begins 8 us after the pin gate enables.
// RULE_06 - Soft start holds the blanking timers disabled.
// RULE_07 - Blanking counter stays zero until feedback drops below low level.
// RULE_08 - Burst entered when 20 ms elapses with feedback still low.
// RULE_09 - Burst entry sets burst flag and turns internal bias off.
// RULE_10 - Startup cell is kept off during burst mode.
// RULE_11 - In burst, feedback above wake level turns bias back on.
// RULE_12 - Reduced current limit is enabled throughout burst mode.
// RULE_13 - In burst, feedback below sleep level turns bias off again.
// RULE_14 - Feedback above high level leaves burst and restores full limit.
// RULE_15 - Faults are mapped to latched off or auto restart.
// RULE_16 - External latch enable on the blanking pin forces latched off.
// RULE_17 - Latched off persists until supply falls below reset level.
// RULE_18 - Overvoltage needs high supply and high feedback together.
// RULE_19 - Secondary short detection latches off at once.
// RULE_20 - Pin pulled low latches off, ignored for 1 ms after startup.
// RULE_21 - Overtemperature and overvoltage pass an 8 us spike filter.
// RULE_22 - Comparators synchronised; durations counted in timebase cycles.
// RULE_23 - Latch wins over auto restart; auto restart reruns soft start.
`include "smc_regs.svh"

module smc_control_unit #(
	parameter int unsigned BLANK_CYCLES = `SMC_BLANK_CYCLES,
	parameter int unsigned ARM_CYCLES   = `SMC_ARM_CYCLES
) (
	// Clock and reset
	input  wire logic                clk_in,
	input  wire logic                reset_in,
	// Comparator levels, asynchronous to the timebase
	input  wire smc_pkg::smc_cmp_t   cmp_in,
	// Soft-start block, same clock
	input  wire logic                soft_start_active_in,
	// Analogue controls
	output smc_pkg::smc_drive_t      drive_out,
	output smc_pkg::smc_mode_t       mode_out,
	output logic                     soft_start_restart_out
);

	import smc_pkg::*;

	// ***********************************************************************
	// Mode decoding
	// ***********************************************************************
	// The burst and overload timers only run from normal operation outside soft start, so every
	// other mode, and each fresh start, leaves them cleared.
	function automatic logic timers_free(input smc_mode_t mode,
	                                     input logic      soft_start);
		return (mode == MODE_NORMAL) && !soft_start;
	endfunction : timers_free

	function automatic logic in_burst(input smc_mode_t mode);
		return mode == MODE_BURST;
	endfunction : in_burst

	function automatic logic in_fault(input smc_mode_t mode);
		return (mode == MODE_AUTO_RESTART) || (mode == MODE_LATCHED);
	endfunction : in_fault

	// ***********************************************************************
	// Synchronised comparator levels
	// ***********************************************************************
	smc_cmp_t  cmp;
	smc_mode_t mode_reg;
	smc_mode_t mode_next;
	logic      restart_reg;

	smc_sync #(
		.WIDTH    ($bits(smc_cmp_t))
	) u_sync (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.async_in (cmp_in),
		.sync_out (cmp)                             // [RULE_22]
	);

	// ***********************************************************************
	// Blanking timers
	// ***********************************************************************
	logic burst_run;
	logic burst_done;
	logic overload_run;
	logic overload_done;
	logic restart_gate;
	logic restart_run;
	logic restart_done;
	logic ov_run;
	logic ov_done;
	logic ot_done;
	logic arm_done;

	// Both timers idle at zero outside normal running and while soft start is
	// active, so startup transients never count towards a mode change.
	assign burst_run    = timers_free(mode_reg, soft_start_active_in)
	                      && cmp.fb_below_enter;     // [RULE_06] [RULE_07]
	assign overload_run = timers_free(mode_reg, soft_start_active_in)
	                      && cmp.fb_above_high;      // [RULE_06]

	smc_blank_timer #(
		.WIDTH    (`SMC_BLANK_WIDTH),
		.LIMIT    (BLANK_CYCLES)
	) u_burst_timer (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.run_in   (burst_run),
		.done_out (burst_done)                      // [RULE_01] [RULE_22]
	);

	smc_blank_timer #(
		.WIDTH    (`SMC_BLANK_WIDTH),
		.LIMIT    (BLANK_CYCLES)
	) u_overload_timer (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.run_in   (overload_run),
		.done_out (overload_done)                   // [RULE_01]
	);

	// With no capacitor the pin reaches the upper level at once after the
	// clamp opens, which gives the basic interval; a capacitor extends it.
	assign restart_gate = overload_done && cmp.bl_upper; // [RULE_02] [RULE_03]
	assign restart_run  = restart_gate;

	smc_blank_timer #(
		.WIDTH    (`SMC_SPIKE_WIDTH),
		.LIMIT    (`SMC_SPIKE_CYCLES)
	) u_restart_spike (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.run_in   (restart_run),
		.done_out (restart_done)                    // [RULE_05]
	);

	assign ov_run = cmp.vcc_over && cmp.fb_above_high; // [RULE_18]

	smc_blank_timer #(
		.WIDTH    (`SMC_SPIKE_WIDTH),
		.LIMIT    (`SMC_SPIKE_CYCLES)
	) u_ov_spike (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.run_in   (ov_run),
		.done_out (ov_done)                         // [RULE_21]
	);

	smc_blank_timer #(
		.WIDTH    (`SMC_SPIKE_WIDTH),
		.LIMIT    (`SMC_SPIKE_CYCLES)
	) u_ot_spike (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.run_in   (cmp.over_temp),
		.done_out (ot_done)                         // [RULE_21]
	);

	// Runs once from reset and then holds done, arming the external latch.
	smc_blank_timer #(
		.WIDTH    (`SMC_ARM_WIDTH),
		.LIMIT    (ARM_CYCLES)
	) u_latch_arm (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.run_in   (1'b1),
		.done_out (arm_done)                        // [RULE_20]
	);

	// ***********************************************************************
	// Fault requests
	// ***********************************************************************
	logic latch_req;
	logic restart_req;
	logic restart_clear;

	assign latch_req   = ov_done || ot_done || cmp.sec_short  // [RULE_19]
	                     || (arm_done && cmp.bl_low);  // [RULE_15] [RULE_16]
	assign restart_req = restart_done || cmp.vcc_under; // [RULE_15]

	// A shorted optocoupler shows up as undervoltage, so it needs no input.
	assign restart_clear = !cmp.vcc_under && !cmp.fb_above_high;

	// ***********************************************************************
	// Mode sequencing
	// ***********************************************************************
	always_comb begin
		mode_next = mode_reg;
		unique case (mode_reg)
			MODE_NORMAL: begin
				if (latch_req) begin
					mode_next = MODE_LATCHED;          // [RULE_23]
				end else if (restart_req) begin
					mode_next = MODE_AUTO_RESTART;
				end else if (burst_done) begin
					mode_next = MODE_BURST;            // [RULE_08]
				end
			end
			MODE_BURST: begin
				if (latch_req) begin
					mode_next = MODE_LATCHED;
				end else if (cmp.vcc_under) begin
					mode_next = MODE_AUTO_RESTART;
				end else if (cmp.fb_above_high) begin
					mode_next = MODE_NORMAL;           // [RULE_14]
				end
			end
			MODE_AUTO_RESTART: begin
				if (latch_req) begin
					mode_next = MODE_LATCHED;          // [RULE_23]
				end else if (restart_clear) begin
					mode_next = MODE_NORMAL;           // [RULE_23]
				end
			end
			MODE_LATCHED: begin
				if (cmp.vcc_below_reset) begin
					mode_next = MODE_NORMAL;           // [RULE_17]
				end
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			mode_reg <= MODE_NORMAL;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// Leaving auto restart or latched off starts a fresh soft start.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			restart_reg <= 1'b0;
		end else begin
			restart_reg <= (mode_next == MODE_NORMAL)
			               && in_fault(mode_reg);  // [RULE_23]
		end
	end

	// ***********************************************************************
	// Analogue drive
	// ***********************************************************************
	logic bias_reg;
	logic burst_flag_reg;
	logic reduced_reg;
	logic cell_off_reg;
	logic clamp_reg;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			bias_reg <= `SMC_RST_BIAS_ON;
		end else if (in_burst(mode_next)) begin
			if (!in_burst(mode_reg)) begin
				bias_reg <= 1'b0;                      // [RULE_09]
			end else if (cmp.fb_above_wake) begin
				bias_reg <= 1'b1;                      // [RULE_11]
			end else if (cmp.fb_below_sleep && burst_flag_reg) begin
				bias_reg <= 1'b0;                      // [RULE_13]
			end
		end else begin
			bias_reg <= (mode_next == MODE_NORMAL);
		end
	end

	// Flag, reduced limit and startup cell follow burst mode exactly, so
	// they drop on the same edge that leaves it.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			burst_flag_reg <= `SMC_RST_BURST_FLAG;
		end else begin
			burst_flag_reg <= in_burst(mode_next);     // [RULE_09]
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			reduced_reg <= `SMC_RST_REDUCED;
		end else begin
			reduced_reg <= in_burst(mode_next);        // [RULE_12] [RULE_14]
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cell_off_reg <= `SMC_RST_CELL_OFF;
		end else begin
			cell_off_reg <= in_burst(mode_next);       // [RULE_10]
		end
	end

	// The clamp opens once the overload interval expires and closes again
	// as soon as feedback recovers or a mode is entered.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			clamp_reg <= `SMC_RST_CLAMP;
		end else begin
			clamp_reg <= !overload_done;               // [RULE_04]
		end
	end

	// ***********************************************************************
	// Outputs
	// ***********************************************************************
	assign drive_out              = '{
		bias_on:          bias_reg,
		startup_cell_off: cell_off_reg,
		reduced_limit:    reduced_reg,
		clamp_closed:     clamp_reg,
		burst_flag:       burst_flag_reg
	};
	assign mode_out               = mode_reg;
	assign soft_start_restart_out = restart_reg;

endmodule : smc_control_unit

/* File: rtl/smc_regs.svh */
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// ***********************************************************************
// Timebase
// ***********************************************************************
`define SMC_CLK_MHZ           100

// ***********************************************************************
// Blanking and spike-blanking times, with their cycle counts
// ***********************************************************************
`define SMC_BLANK_TIME_US     20000
`define SMC_BLANK_CYCLES      (`SMC_BLANK_TIME_US * `SMC_CLK_MHZ)
`define SMC_BLANK_WIDTH       21
`define SMC_SPIKE_TIME_NS     8000
`define SMC_SPIKE_CYCLES      ((`SMC_SPIKE_TIME_NS * `SMC_CLK_MHZ) / 1000)
`define SMC_SPIKE_WIDTH       10
`define SMC_ARM_TIME_US       1000
`define SMC_ARM_CYCLES        (`SMC_ARM_TIME_US * `SMC_CLK_MHZ)
`define SMC_ARM_WIDTH         17

// ***********************************************************************
// Reset values of the drive outputs
// ***********************************************************************
`define SMC_RST_BIAS_ON       1'b1
`define SMC_RST_CELL_OFF      1'b0
`define SMC_RST_REDUCED       1'b0
`define SMC_RST_CLAMP         1'b1
`define SMC_RST_BURST_FLAG    1'b0

`endif

/* File: rtl/smc_pkg.sv */
package smc_pkg;

	// ***********************************************************************
	// Operating modes
	// ***********************************************************************
	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_BURST,
		MODE_AUTO_RESTART,
		MODE_LATCHED
	} smc_mode_t;

	// ***********************************************************************
	// Comparator levels arriving from the analogue side
	// ***********************************************************************
	typedef struct packed {
		logic fb_below_enter;
		logic fb_above_wake;
		logic fb_below_sleep;
		logic fb_above_high;
		logic bl_upper;
		logic bl_low;
		logic vcc_over;
		logic vcc_under;
		logic vcc_below_reset;
		logic over_temp;
		logic sec_short;
	} smc_cmp_t;

	// ***********************************************************************
	// Controls driven back into the analogue side
	// ***********************************************************************
	typedef struct packed {
		logic bias_on;
		logic startup_cell_off;
		logic reduced_limit;
		logic clamp_closed;
		logic burst_flag;
	} smc_drive_t;

endpackage : smc_pkg

/* File: rtl/smc_sync.sv */
module smc_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_reg;

	// Each bit is its own two-stage chain; bits are not coherent as a word.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_in or posedge reset_in) begin
				if (reset_in) begin
					stage_reg[i] <= 1'b0;
					sync_out[i]  <= 1'b0;
				end else begin
					stage_reg[i] <= async_in[i];
					sync_out[i]  <= stage_reg[i];
				end
			end
		end
	endgenerate

endmodule : smc_sync

/* File: rtl/smc_blank_timer.sv */
module smc_blank_timer #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned LIMIT = 10
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic reset_in,
	// Control
	input  wire logic run_in,
	output logic      done_out
);

	logic [WIDTH-1:0] count_reg;

	// The count is cleared whenever the qualifying condition drops, so a
	// brief condition never accumulates across separate episodes.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			count_reg <= '0;
		end else if (!run_in) begin
			count_reg <= '0;
		end else if (count_reg != WIDTH'(LIMIT)) begin
			count_reg <= count_reg + WIDTH'(1);
		end
	end

	assign done_out = run_in && (count_reg == WIDTH'(LIMIT));

endmodule : smc_blank_timer

/* File: bench/smc_control_unit_assertions.sv */
module smc_control_unit_assertions #(
	parameter int unsigned BLANK_CYCLES = 50,
	parameter int unsigned ARM_CYCLES   = 20
) (
	// Clock and reset
	input wire logic                clk_in,
	input wire logic                reset_in,
	// Block ports
	input wire smc_pkg::smc_cmp_t   cmp_in,
	input wire logic                soft_start_active_in,
	input wire smc_pkg::smc_drive_t drive_out,
	input wire smc_pkg::smc_mode_t  mode_out,
	input wire logic                soft_start_restart_out
);
	import smc_pkg::*;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	// ****************************************************************
	// Raw-input run lengths
	// ****************************************************************
	// Counts see the pins before the sync stages, so they only bound timing
	// from below.
	int unsigned low_cnt;
	int unsigned high_cnt;
	int unsigned up_cnt;
	int unsigned uv_cnt;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			low_cnt  <= 0;
			high_cnt <= 0;
			up_cnt   <= 0;
			uv_cnt   <= 99;
		end else begin
			low_cnt  <= (cmp_in.fb_below_enter && !soft_start_active_in) ?
				low_cnt + 1 : 0;
			high_cnt <= (cmp_in.fb_above_high && !soft_start_active_in) ?
				high_cnt + 1 : 0;
			up_cnt   <= cmp_in.bl_upper ? up_cnt + 1 : 0;
			uv_cnt   <= cmp_in.vcc_under ? 0 : (uv_cnt < 99 ? uv_cnt + 1 : 99);
		end
	end

	burst_drive_a:
		assert property (mode_out == MODE_BURST |-> drive_out.burst_flag &&
			drive_out.reduced_limit && drive_out.startup_cell_off)
		else $error("burst outputs wrong");
	full_limit_a:
		assert property (mode_out != MODE_BURST |->
			!drive_out.reduced_limit && !drive_out.burst_flag)
		else $error("reduced limit outside burst");
	burst_entry_a:
		assert property (mode_out == MODE_NORMAL ##1 mode_out == MODE_BURST
			|-> low_cnt >= BLANK_CYCLES)
		else $error("burst entered too early");
	clamp_open_a:
		assert property ($fell(drive_out.clamp_closed) |->
			high_cnt >= BLANK_CYCLES)
		else $error("clamp released too early");
	ar_entry_a:
		assert property (mode_out == MODE_NORMAL ##1
			mode_out == MODE_AUTO_RESTART |-> up_cnt >= 800 || uv_cnt < 8)
		else $error("auto restart too early");
	latch_hold_a:
		assert property ((mode_out == MODE_LATCHED &&
			!cmp_in.vcc_below_reset)[*3] |=> mode_out == MODE_LATCHED)
		else $error("latched mode left");
	short_latch_a:
		assert property ((cmp_in.sec_short && !cmp_in.vcc_below_reset)[*4]
			|-> mode_out == MODE_LATCHED)
		else $error("short did not latch");
	restart_pulse_a:
		assert property (soft_start_restart_out |-> mode_out == MODE_NORMAL &&
			$past(mode_out) != MODE_NORMAL ##1 !soft_start_restart_out)
		else $error("restart pulse wrong");
endmodule : smc_control_unit_assertions

/* File: bench/smc_far_side.sv */
module smc_far_side #(
	parameter int unsigned CHARGE_CYCLES = 30
) (
	// Clock
	input  wire logic        clk_in,
	// Analogue stimulus
	input  wire logic [12:0] fb_mv_in,
	input  wire logic        clamp_closed_in,
	input  wire logic        pull_low_in,
	input  wire logic [4:0]  fault_in,
	// Comparator levels
	output smc_pkg::smc_cmp_t cmp_out
);
	import smc_pkg::*;

	// The capacitor charges only while the clamp is open and nothing pulls
	// the pin down, so the upper level lags the release.
	int unsigned charge = 0;
	always_ff @(posedge clk_in) begin
		if (clamp_closed_in || pull_low_in)
			charge <= 0;
		else if (charge < CHARGE_CYCLES)
			charge <= charge + 1;
	end

	assign cmp_out = {fb_mv_in < 13'h0546, fb_mv_in > 13'h0E1A,
		fb_mv_in < 13'h0BB8, fb_mv_in > 13'h1194,
		charge >= CHARGE_CYCLES, pull_low_in, fault_in};
endmodule : smc_far_side

/* File: bench/test_smc_control_unit.sv */
module test_smc_control_unit;
	timeunit 1ns;
	timeprecision 1ns;
	import smc_pkg::*;

	localparam int unsigned BLANK = 50;
	localparam int unsigned ARM   = 20;
	logic        clk_in     = 1'b0;
	logic        reset_in   = 1'b1;
	logic        soft_start = 1'b0;
	logic        pull_low   = 1'b0;
	logic [12:0] fb_mv      = 13'h07D0;
	logic [4:0]  fault      = 5'h00;
	logic [4:0]  lat [3]    = '{5'h09, 5'h02, 5'h10};
	smc_cmp_t    cmp;
	smc_drive_t  drive;
	smc_mode_t   mode;
	smc_mode_t   notes [$];
	logic        restart;
	int          pulses     = 0;
	int          bad_count  = 0;
	int          checked    = 0;
	int          cycles     = 0;

	smc_far_side #(.CHARGE_CYCLES(30)) u_smc_far_side (.clk_in(clk_in),
		.fb_mv_in(fb_mv), .clamp_closed_in(drive.clamp_closed),
		.pull_low_in(pull_low), .fault_in(fault), .cmp_out(cmp));
	smc_control_unit #(.BLANK_CYCLES(BLANK), .ARM_CYCLES(ARM))
		u_smc_control_unit (.clk_in(clk_in), .reset_in(reset_in),
		.cmp_in(cmp), .soft_start_active_in(soft_start), .drive_out(drive),
		.mode_out(mode), .soft_start_restart_out(restart));

	initial forever #5 clk_in = ~clk_in;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : cyc

	task automatic look(input logic seen, input logic exp);
		@(negedge clk_in);
		check(8'(seen), 8'(exp));
		@(posedge clk_in);
	endtask : look

	// A mode change that never comes is reported once the bound runs out.
	task automatic settle(input int n);
		for (int i = 0; i < n && notes.size() != 0; i++)
			@(posedge clk_in);
		check(8'(notes.size()), 8'h00);
		notes.delete();
	endtask : settle

	// ****************************************************************
	// Mode monitor
	// ****************************************************************
	always @(mode) begin
		if (!reset_in)
			check(8'(mode), notes.size() ? 8'(notes.pop_front()) : 8'hFF);
	end

	// One soft-start request is counted for each exit from a fault mode.
	always @(posedge clk_in) begin
		cycles++;
		if (restart === 1'b1)
			pulses++;
		if (cycles == 12000) begin
			bad_count++;
			final_report();
		end
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		void'($urandom(32'h1F8254E0));
		cyc(3);
		look(drive === 5'h12, 1'b1);
		reset_in <= 1'b0;
		pull_low <= 1'b1;
		soft_start <= 1'b1;
		cyc(ARM / 2);
		pull_low <= 1'b0;
		fb_mv <= 13'h01F4 + 13'($urandom_range(800));
		cyc(BLANK + 20);
		soft_start <= 1'b0;
		fb_mv <= 13'h07D0;
		cyc(5);
		fb_mv <= 13'h03E8;
		cyc(1 + $urandom_range(BLANK - 10));
		fb_mv <= 13'h07D0;
		cyc(BLANK + 10);
		notes.push_back(MODE_BURST);
		fb_mv <= 13'h01F4 + 13'($urandom_range(800));
		settle(BLANK + 10);
		look(drive.bias_on, 1'b0);
		fb_mv <= 13'h0E74;
		cyc(6);
		look(drive.bias_on, 1'b1);
		fb_mv <= 13'h0B54;
		cyc(6);
		look(drive.bias_on, 1'b0);
		look(drive.reduced_limit, 1'b1);
		notes.push_back(MODE_NORMAL);
		fb_mv <= 13'h11F8;
		settle(10);
		fb_mv <= 13'h07D0;
		look(drive.reduced_limit, 1'b0);
		notes.push_back(MODE_AUTO_RESTART);
		fb_mv <= 13'h11F8;
		settle(920);
		notes.push_back(MODE_NORMAL);
		fb_mv <= 13'h07D0;
		settle(10);
		notes.push_back(MODE_AUTO_RESTART);
		fault <= 5'h08;
		settle(10);
		notes.push_back(MODE_NORMAL);
		fault <= 5'h00;
		settle(10);
		fault <= 5'h10;
		cyc(830);
		for (int k = 0; k < 4; k++) begin
			notes.push_back(MODE_LATCHED);
			if (k == 3)
				pull_low <= 1'b1;
			else
				fault <= lat[k];
			if (k == 2)
				fb_mv <= 13'h11F8;
			settle(820);
			fault <= 5'h00;
			pull_low <= 1'b0;
			fb_mv <= 13'h07D0;
			cyc(20);
			notes.push_back(MODE_NORMAL);
			fault <= 5'h04;
			settle(10);
			fault <= 5'h00;
			cyc(5);
		end
		check(8'(pulses), 8'h06);
		final_report();
	end
endmodule : test_smc_control_unit

bind smc_control_unit smc_control_unit_assertions #(
	.BLANK_CYCLES(BLANK_CYCLES),
	.ARM_CYCLES(ARM_CYCLES)
) u_smc_control_unit_assertions (
	.clk_in(clk_in),
	.reset_in(reset_in),
	.cmp_in(cmp_in),
	.soft_start_active_in(soft_start_active_in),
	.drive_out(drive_out),
	.mode_out(mode_out),
	.soft_start_restart_out(soft_start_restart_out)
);
